// ===== hdl/lfd_pkg.sv
// Shared constants and types for the downstream line-fault diagnosis block.
package lfd_pkg;

  // Cause codes for faults found while the bus is being discovered.
  localparam logic [7:0] CODE_OPEN        = 8'h0C;
  localparam logic [7:0] CODE_WRONG_PORT  = 8'h0D;
  localparam logic [7:0] CODE_REVERSED    = 8'h0D;
  localparam logic [7:0] CODE_LINE_SHORT  = 8'h0B;
  localparam logic [7:0] CODE_POS_GND     = 8'h09;
  localparam logic [7:0] CODE_NEG_VBAT    = 8'h0A;
  localparam logic [7:0] CODE_NEG_GND     = 8'h29;
  localparam logic [7:0] CODE_POS_VBAT    = 8'h2A;
  localparam logic [7:0] CODE_DISC_TMO    = 8'h18;

  // Cause codes for line events seen after discovery.
  localparam logic [7:0] CODE_LINE_EVT    = 8'h0F;
  localparam logic [7:0] CODE_POWER_EVT   = 8'h80;
  localparam logic [7:0] CODE_BIAS_EVT    = 8'h05;

  localparam logic [7:0] CAUSE_RESET      = 8'h00;

  // Discovery reply window, in its own unit and as a cycle count at 25 MHz.
  localparam int CLK_PERIOD_NS   = 40;
  localparam int DISC_TIMEOUT_NS = 100000;
  localparam logic [15:0] DISC_TIMEOUT_CYC =
    16'((DISC_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int DELAY_W = 8;

  // Gray-coded along idle -> discover -> run, with fault beside idle and run.
  typedef enum logic [1:0] {
    LFD_IDLE  = 2'b00,
    LFD_DISC  = 2'b01,
    LFD_RUN   = 2'b11,
    LFD_FAULT = 2'b10
  } lfd_state_t;

endpackage

// ===== hdl/lfd_tmr_if.sv
// Carrier between the diagnosis controller and its discovery reply timer.
`timescale 1ns/100ps
interface lfd_tmr_if;
  logic                       start;
  logic                       stop;
  logic [lfd_pkg::DELAY_W-1:0] delay;
  logic                       expired;

  modport ctrl (output start, output stop, output delay, input expired);
  modport tmr  (input start, input stop, input delay, output expired);
endinterface

// ===== hdl/lfd_timer.sv
// Discovery reply timer: pulses expired when no reply came in the window.
`timescale 1ns/100ps
module lfd_timer #(
  parameter logic [15:0] TIMEOUT_CYC = lfd_pkg::DISC_TIMEOUT_CYC
) (
  input  wire logic clk_i,   // System clock.
  input  wire logic rst_n_i, // Synchronised reset, active low.
  lfd_tmr_if.tmr    tif      // Start, stop and expiry toward the controller.
);
  import lfd_pkg::*;

  logic [16:0] cnt_r;
  logic        run_r;
  logic        exp_r;

  // The programmed reply delay lengthens the window, so a wrong delay
  // value ends as a timeout rather than as a false reply.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 17'h00000;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      exp_r <= 1'b0;
      if (tif.start) begin
        cnt_r <= {1'b0, TIMEOUT_CYC} + {9'h000, tif.delay};
        run_r <= 1'b1;
      end else if (tif.stop) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        cnt_r <= cnt_r - 17'h00001;
        if (cnt_r == 17'h00001) begin
          run_r <= 1'b0;
          exp_r <= 1'b1;
        end
      end
    end
  end

  assign tif.expired = exp_r;

  AST_TMR_EXPIRE_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    exp_r |-> $past(run_r) && $past(cnt_r) == 17'h00001 && !$past(tif.start))
    else $error("Timer expired without counting down to one.");

endmodule

// ===== hdl/lfd_top.sv
// Downstream line-fault diagnosis: fault coding, bias cut-off and cause reporting.
//
// Functional notes
// - Any fault found during discovery opens the downstream bias switches at once.
// - An open positive, negative or both downstream wires reports cause 0x0C.
// - Downstream cabled to the next node's downstream port reports 0x0C or 0x0D.
// - Reversed wiring seen by the detectors reports cause 0x0D.
// - Reversed wiring the detectors miss ends as timeout 0x18 with no discovery done.
// - A dead next node or a wrong reply delay ends as timeout 0x18 with no discovery done.
// - Positive line shorted to ground reports cause 0x09.
// - Negative line shorted to battery reports cause 0x0A.
// - Negative-to-ground reports 0x29 and positive-to-battery 0x2A; the host then localises.
// - Critical faults other than negative-to-ground are isolated here by shutting down downstream.
// - Non-critical faults leave the upstream side free to keep communicating.
// - Full line diagnostics run only during discovery; a later fault needs a new discovery.
// - After discovery enabled line events report 0x0F, 0x80 or 0x05.
// - Line events after discovery raise an interrupt only when enabled.
`timescale 1ns/100ps
module lfd_top #(
  parameter logic [15:0] TIMEOUT_CYC = lfd_pkg::DISC_TIMEOUT_CYC
) (
  input  wire logic                       clk_i,           // System clock, 25 MHz.
  input  wire logic                       reset_n_i,       // Asynchronous reset, active low.
  input  wire logic                       disc_start_i,    // Pulse: begin (re)discovery.
  input  wire logic [lfd_pkg::DELAY_W-1:0] discovery_reply_delay_i, // Reply delay setting.
  input  wire logic                       node_reply_i,    // Pulse: next node answered.
  input  wire logic                       pos_open_i,      // Positive wire open.
  input  wire logic                       neg_open_i,      // Negative wire open.
  input  wire logic                       wrong_port_i,    // Cabled to a downstream port.
  input  wire logic                       reversed_i,      // Wires swapped.
  input  wire logic                       line_short_i,    // Wires shorted together.
  input  wire logic                       pos_gnd_i,       // Positive shorted to ground.
  input  wire logic                       neg_vbat_i,      // Negative shorted to battery.
  input  wire logic                       neg_gnd_i,       // Negative shorted to ground.
  input  wire logic                       pos_vbat_i,      // Positive shorted to battery.
  input  wire logic                       line_evt_i,      // Line event after discovery.
  input  wire logic                       power_evt_i,     // Power event after discovery.
  input  wire logic                       bias_evt_i,      // Bias event after discovery.
  input  wire logic                       line_evt_en_i,   // Enable for line event.
  input  wire logic                       power_evt_en_i,  // Enable for power event.
  input  wire logic                       bias_evt_en_i,   // Enable for bias event.
  input  wire logic                       cause_ack_i,     // Pulse: host read or cleared cause.
  output logic [7:0]                      irq_cause_code_o, // Latest cause code.
  output logic                            irq_o,           // Interrupt, active high.
  output logic                            discovery_complete_irq_o, // Discovery succeeded.
  output logic                            bias_en_o,       // Downstream bias switches closed.
  output logic                            down_shutdown_o, // Downstream bus shut down.
  output logic                            upstream_en_o    // Upstream side may communicate.
);
  import lfd_pkg::*;

  logic       rst_s1_r;
  logic       rst_n;
  lfd_state_t state_r;
  logic       crit_fault;
  logic       any_fault;
  logic       flt_set;
  logic [7:0] flt_code;
  logic       evt_set;
  logic [7:0] evt_code;
  logic       tmo_set;
  logic       cause_set;
  logic [7:0] cause_nxt;

  lfd_tmr_if tif ();

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  lfd_timer #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .tif     (tif)
  );

  // Detectors are only looked at while discovering.
  assign crit_fault = pos_gnd_i | neg_vbat_i | neg_gnd_i | pos_vbat_i;
  assign any_fault  = crit_fault | line_short_i | reversed_i | wrong_port_i
                    | pos_open_i | neg_open_i;
  assign flt_set    = (state_r == LFD_DISC) && any_fault && !disc_start_i;

  // Critical faults first, since they take the bus down.
  always_comb begin
    if (pos_gnd_i) begin
      flt_code = CODE_POS_GND;
    end else if (neg_vbat_i) begin
      flt_code = CODE_NEG_VBAT;
    end else if (neg_gnd_i) begin
      flt_code = CODE_NEG_GND;
    end else if (pos_vbat_i) begin
      flt_code = CODE_POS_VBAT;
    end else if (line_short_i) begin
      flt_code = CODE_LINE_SHORT;
    end else if (reversed_i) begin
      flt_code = CODE_REVERSED;
    end else if (wrong_port_i) begin
      flt_code = CODE_WRONG_PORT;
    end else begin
      flt_code = CODE_OPEN;
    end
  end

  // A reply in the same cycle as expiry counts as a reply.
  assign tmo_set = (state_r == LFD_DISC) && tif.expired && !any_fault
                 && !node_reply_i && !disc_start_i;

  always_comb begin
    evt_set  = 1'b0;
    evt_code = CODE_LINE_EVT;
    if (state_r == LFD_RUN && !disc_start_i) begin
      if (line_evt_i && line_evt_en_i) begin
        evt_set  = 1'b1;
        evt_code = CODE_LINE_EVT;
      end else if (power_evt_i && power_evt_en_i) begin
        evt_set  = 1'b1;
        evt_code = CODE_POWER_EVT;
      end else if (bias_evt_i && bias_evt_en_i) begin
        evt_set  = 1'b1;
        evt_code = CODE_BIAS_EVT;
      end
    end
  end

  assign cause_set = flt_set | tmo_set | evt_set;
  assign cause_nxt = flt_set ? flt_code : (tmo_set ? CODE_DISC_TMO : evt_code);

  assign tif.start = disc_start_i;
  assign tif.stop  = (state_r == LFD_DISC) && (any_fault || node_reply_i);
  assign tif.delay = discovery_reply_delay_i;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= LFD_IDLE;
    end else if (disc_start_i) begin
      state_r <= LFD_DISC;
    end else if (state_r == LFD_DISC) begin
      if (flt_set || tmo_set) begin
        state_r <= LFD_FAULT;
      end else if (node_reply_i) begin
        state_r <= LFD_RUN;
      end
    end
  end

  // Bias and shutdown only change on a discovery start or a discovery fault.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bias_en_o       <= 1'b0;
      down_shutdown_o <= 1'b0;
      upstream_en_o   <= 1'b1;
    end else if (disc_start_i) begin
      bias_en_o       <= 1'b1;
      down_shutdown_o <= 1'b0;
      upstream_en_o   <= 1'b1;
    end else if (flt_set || tmo_set) begin
      bias_en_o <= 1'b0;
      // Negative-to-ground is seen by every node, so it is not isolated here.
      if (pos_gnd_i || neg_vbat_i || pos_vbat_i) begin
        down_shutdown_o <= 1'b1;
      end
      upstream_en_o <= !crit_fault;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      discovery_complete_irq_o <= 1'b0;
    end else if (disc_start_i) begin
      discovery_complete_irq_o <= 1'b0;
    end else if (state_r == LFD_DISC && node_reply_i && !any_fault) begin
      discovery_complete_irq_o <= 1'b1;
    end
  end

  // A new cause wins over a host acknowledge in the same cycle.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_cause_code_o <= CAUSE_RESET;
      irq_o            <= 1'b0;
    end else if (cause_set) begin
      irq_cause_code_o <= cause_nxt;
      irq_o            <= 1'b1;
    end else if (cause_ack_i) begin
      irq_o <= 1'b0;
    end
  end

  AST_BIAS_OFF: assert property (@(posedge clk_i) disable iff (!rst_n)
    flt_set |=> !bias_en_o && state_r == LFD_FAULT)
    else $error("Bias stayed on after a discovery fault.");

  AST_OPEN_CODE: assert property (@(posedge clk_i) disable iff (!rst_n)
    flt_set && !crit_fault && !line_short_i && !reversed_i && !wrong_port_i
    |=> irq_cause_code_o == 8'h0C && irq_o)
    else $error("Open wire not reported as 0x0C.");

  AST_WRONG_PORT: assert property (@(posedge clk_i) disable iff (!rst_n)
    flt_set && wrong_port_i && !crit_fault && !line_short_i
    |=> irq_cause_code_o inside {8'h0C, 8'h0D})
    else $error("Wrong port not reported as 0x0C or 0x0D.");

  AST_TIMEOUT: assert property (@(posedge clk_i) disable iff (!rst_n)
    tmo_set |=> irq_cause_code_o == 8'h18 && !discovery_complete_irq_o && !bias_en_o)
    else $error("Discovery timeout not reported as 0x18.");

  AST_POS_GND: assert property (@(posedge clk_i) disable iff (!rst_n)
    flt_set && pos_gnd_i |=> irq_cause_code_o == 8'h09 && down_shutdown_o)
    else $error("Positive short to ground not reported as 0x09.");

  AST_NEG_VBAT: assert property (@(posedge clk_i) disable iff (!rst_n)
    flt_set && neg_vbat_i && !pos_gnd_i |=> irq_cause_code_o == 8'h0A)
    else $error("Negative short to battery not reported as 0x0A.");

  AST_NEG_GND_NO_ISOLATE: assert property (@(posedge clk_i) disable iff (!rst_n)
    flt_set && neg_gnd_i && !pos_gnd_i && !neg_vbat_i && !pos_vbat_i
    |=> irq_cause_code_o == 8'h29 && !down_shutdown_o && !upstream_en_o)
    else $error("Negative short to ground handled wrongly.");

  AST_UPSTREAM_KEPT: assert property (@(posedge clk_i) disable iff (!rst_n)
    flt_set && !crit_fault |=> upstream_en_o && !down_shutdown_o)
    else $error("Upstream dropped on a non-critical fault.");

  AST_DIAG_ONLY_DISC: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_r != LFD_DISC && !disc_start_i |=> $stable(bias_en_o) && $stable(down_shutdown_o))
    else $error("Line diagnostics acted outside discovery.");

  AST_EVT_MASKED: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_r == LFD_RUN && !irq_o && !(line_evt_i && line_evt_en_i)
    && !(power_evt_i && power_evt_en_i) && !(bias_evt_i && bias_evt_en_i) |=> !irq_o)
    else $error("Interrupt raised by a masked line event.");

  AST_IRQ_HELD: assert property (@(posedge clk_i) disable iff (!rst_n)
    irq_o && !cause_ack_i |=> irq_o [*1] ##0 $stable(irq_cause_code_o) || $past(cause_set))
    else $error("Interrupt or cause dropped without acknowledge.");

endmodule

// ===== testbench/lfd_next_node.sv
// Behavioural model of the next-in-line node on the downstream cable.
`timescale 1ns/100ps
module lfd_next_node (
  input  wire logic       clk_i,        // System clock.
  input  wire logic       bias_en_i,    // Bias current from the upstream node.
  input  wire logic       reply_en_i,   // Node is healthy and answers discovery.
  input  wire logic [7:0] reply_wait_i, // Cycles from power-up to the reply.
  input  wire logic [8:0] fault_i,      // Cable fault chosen by the bench.
  output logic            node_reply_o, // One-cycle discovery reply.
  output logic [8:0]      det_o         // Fault detector levels seen upstream.
);
  logic [8:0] wait_r = 9'h000;
  logic       bias_r = 1'b0;

  assign det_o = fault_i;

  always_ff @(posedge clk_i) begin
    bias_r       <= bias_en_i;
    node_reply_o <= 1'b0;
    if (bias_en_i && !bias_r) begin
      wait_r <= {1'b0, reply_wait_i};
    end else if (bias_en_i && wait_r != 9'h000) begin
      wait_r <= wait_r - 9'h001;
      // A dead node or a faulted cable never answers; a dead node leaves discovery to time out.
      node_reply_o <= (wait_r == 9'h001) && reply_en_i && (fault_i == 9'h000);
    end
  end
endmodule

// ===== testbench/lfd_tb_top.sv
// Self-checking testbench for the downstream line-fault diagnosis block.
`timescale 1ns/100ps
module lfd_tb_top;
  import lfd_pkg::*;
  localparam logic [15:0] TMO = 16'h0014;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       start = 1'b0;
  logic [7:0] dly = 8'h00;
  logic       ack = 1'b0;
  logic       reply_en = 1'b1;
  logic [7:0] reply_wait = 8'h03;
  logic [8:0] fault = 9'h000;
  logic       ev_l = 1'b0, ev_p = 1'b0, ev_b = 1'b0;
  logic       en_l = 1'b0, en_p = 1'b0, en_b = 1'b0;
  logic       node_reply, irq, done, bias_en, shut, up_en;
  logic [8:0] det;
  logic [7:0] code;
  int         mismatches = 0;
  int         checks = 0;
  int         cyc = 0;

  always #20 clk_i = ~clk_i;

  lfd_top #(.TIMEOUT_CYC(TMO)) dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .disc_start_i(start),
    .discovery_reply_delay_i(dly), .node_reply_i(node_reply),
    .pos_gnd_i(det[8]), .neg_vbat_i(det[7]), .neg_gnd_i(det[6]), .pos_vbat_i(det[5]),
    .line_short_i(det[4]), .reversed_i(det[3]), .wrong_port_i(det[2]),
    .pos_open_i(det[1]), .neg_open_i(det[0]),
    .line_evt_i(ev_l), .power_evt_i(ev_p), .bias_evt_i(ev_b),
    .line_evt_en_i(en_l), .power_evt_en_i(en_p), .bias_evt_en_i(en_b),
    .cause_ack_i(ack), .irq_cause_code_o(code), .irq_o(irq),
    .discovery_complete_irq_o(done), .bias_en_o(bias_en),
    .down_shutdown_o(shut), .upstream_en_o(up_en));

  lfd_next_node node_u (
    .clk_i(clk_i), .bias_en_i(bias_en), .reply_en_i(reply_en),
    .reply_wait_i(reply_wait), .fault_i(fault), .node_reply_o(node_reply), .det_o(det));

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Returns on the edge that samples the start pulse.
  task automatic discover(input logic [7:0] d);
    @(posedge clk_i);
    dly   <= d;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
  endtask

  task automatic await(input bit on_done, input int lim);
    int k;
    k = 0;
    #1;
    while ((on_done ? done : irq) !== 1'b1 && k < lim) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk1(on_done ? done : irq, 1'b1);
  endtask

  task automatic ack_cause();
    @(posedge clk_i);
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    #1;
    chk1(irq, 1'b0);
  endtask

  task automatic fault_case(input logic [8:0] vec, input logic [7:0] exp);
    @(posedge clk_i);
    fault <= vec;
    discover(8'h00);
    await(1'b0, 4);
    chk8(code, exp);
    chk1(bias_en, 1'b0);
    chk1(up_en, ~|vec[8:5]);
    chk1(shut, vec[8] | vec[7] | vec[5]);
    chk1(done, 1'b0);
    ack_cause();
    // The bus is stopped and the cable repaired before the next discovery.
    @(posedge clk_i);
    fault <= 9'h000;
  endtask

  task automatic timeout_case();
    @(posedge clk_i);
    reply_en <= 1'b0;
    discover(8'h05);
    // The window closes TMO plus delay edges after the start; the cause lands one edge later.
    repeat (int'(TMO) + 5) @(posedge clk_i);
    #1;
    chk1(irq, 1'b0);
    @(posedge clk_i);
    #1;
    chk1(irq, 1'b1);
    chk8(code, CODE_DISC_TMO);
    chk1(done, 1'b0);
    chk1(bias_en, 1'b0);
    chk1(up_en, 1'b1);
    chk1(shut, 1'b0);
    ack_cause();
    @(posedge clk_i);
    reply_en <= 1'b1;
  endtask

  task automatic run_case();
    logic [7:0] exp [3];
    exp = '{CODE_LINE_EVT, CODE_POWER_EVT, CODE_BIAS_EVT};
    @(posedge clk_i);
    reply_wait <= 8'h0A;
    discover(8'h00);
    await(1'b1, 16);
    chk1(irq, 1'b0);
    chk1(bias_en, 1'b1);
    // A fault arising after discovery is not diagnosed until rediscovery.
    @(posedge clk_i);
    fault <= 9'h100;
    ev_l  <= 1'b1;
    ev_p  <= 1'b1;
    ev_b  <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk1(irq, 1'b0);
    chk1(bias_en, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      {en_l, en_p, en_b} <= 3'h4 >> i;
      @(posedge clk_i);
      {en_l, en_p, en_b} <= 3'h0;
      await(1'b0, 3);
      chk8(code, exp[i]);
      repeat (3) @(posedge clk_i);
      #1;
      chk1(irq, 1'b1);
      ack_cause();
    end
    // A new cause and an acknowledge in one cycle: the cause must win.
    @(posedge clk_i);
    en_l <= 1'b1;
    ack  <= 1'b1;
    @(posedge clk_i);
    en_l <= 1'b0;
    ack  <= 1'b0;
    #1;
    chk1(irq, 1'b1);
    chk8(code, CODE_LINE_EVT);
    ack_cause();
    @(posedge clk_i);
    fault <= 9'h000;
    ev_l  <= 1'b0;
    ev_p  <= 1'b0;
    ev_b  <= 1'b0;
  endtask

  // A reset in mid-run drops every output to its idle value at once.
  task automatic reset_case();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk8(code, CAUSE_RESET);
    chk1(irq, 1'b0);
    chk1(done, 1'b0);
    chk1(bias_en, 1'b0);
    chk1(up_en, 1'b1);
    chk1(shut, 1'b0);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    discover(8'h00);
    await(1'b1, 16);
    chk1(irq, 1'b0);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk8(code, CAUSE_RESET);
    chk1(irq, 1'b0);
    chk1(bias_en, 1'b0);
    chk1(up_en, 1'b1);
    repeat (4) @(posedge clk_i);
    fault_case(9'h001, CODE_OPEN);
    fault_case(9'h002, CODE_OPEN);
    fault_case(9'h003, CODE_OPEN);
    fault_case(9'h006, CODE_WRONG_PORT);
    fault_case(9'h008, CODE_REVERSED);
    fault_case(9'h010, CODE_LINE_SHORT);
    fault_case(9'h100, CODE_POS_GND);
    fault_case(9'h080, CODE_NEG_VBAT);
    fault_case(9'h040, CODE_NEG_GND);
    fault_case(9'h020, CODE_POS_VBAT);
    timeout_case();
    run_case();
    reset_case();
    results();
  end
endmodule
